// ---- rtl/clocked_serial_unit.sv ----
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "csu_cfg.svh"
// Summary of operation
// - Software loads clock config 07H first.
// - Clock source 111 takes pin serial clock.
// - Frame length field 0000 means 8 bits.
// - Order bit 0 is MSB first; 00 type 1.
// - Control C3H: transmit-only continuous, clock on.
// - Control A3H: receive-only continuous, clock on.
// - Control E3H: transmit and receive continuous.
// - Transmit write sets active flag, awaits clock.
// - Receive-only dummy read sets active flag.
// - Drive output bits with the serial clock.
// - Sample input bits with the serial clock.
// - Holding moved to shifter raises transmit-ready.
// - Transmit-only never raises reception complete.
// - Frame received: raise interrupt, expose word.
// - Preloaded word starts next frame immediately.
// - Receive-only continues while continuous bit set.
// - Receive-only, continuous bit cleared: flag drops at end.
// - Transmit-only without new word: flag drops.
// - Transmit/receive without new word: flag drops.
// - Software writes next word after transmit-ready.
// - Software checks flag zero before power off.
// - Master clocks only after holding written.
// - Unread word overwritten: interrupt, overrun set.
module clocked_serial_unit (
   input wire logic pclk, // System clock
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction, high for write
   input wire logic [11:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error for unmapped addresses
   output logic tx_ready_irq, // Transmit holding free, one-cycle pulse
   output logic rx_done_irq, // Received word ready, one-cycle pulse
   csu_link_if.device link // Serial link to the master
);
   // Configuration and status state
   logic [7:0] main_r;
   logic [7:0] clk_cfg_r;
   logic [3:0] flen_r;
   logic tsf_r;
   logic ovr_r;
   csu_pkg::word_t tx_hold_r;
   logic tx_full_r;
   logic loaded_r;
   csu_pkg::word_t rx_hold_r;
   logic rx_unread_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic tx_irq_r;
   logic rx_irq_r;
   // Decoded controls and events
   logic pwr;
   logic txe;
   logic rxe;
   logic sce;
   logic ext_clk;
   logic [4:0] len;
   logic setup;
   logic finish;
   logic wr_tx;
   logic wr_stat;
   logic rd_rx;
   logic load;
   logic core_done;
   logic core_so;
   csu_pkg::word_t core_rx;
   logic [31:0] rd_mux;
   logic [7:0] stat;

   // Field 0 is the base length; larger codes extend it up to the data width
   function automatic logic [4:0] frame_len(input logic [3:0] cl);
      if (cl == 4'h0)
         return `CSU_LEN_BASE;
      else if (cl > `CSU_FLEN_TOP)
         return `CSU_LEN_MAX;
      else
         return 5'(`CSU_LEN_BASE + {1'b0, cl});
   endfunction : frame_len

   // Only aligned words at the printed offsets are mapped
   function automatic logic addr_ok(input logic [11:0] a);
      return (a == `CSU_OFF_MAIN) || (a == `CSU_OFF_CLK) || (a == `CSU_OFF_FLEN) ||
             (a == `CSU_OFF_STAT) || (a == `CSU_OFF_TX) || (a == `CSU_OFF_RX);
   endfunction : addr_ok

   // Control decode; C3H, A3H and E3H set power, direction enables and continuous bits at once
   assign pwr = main_r[`CSU_MAIN_PWR];
   assign txe = main_r[`CSU_MAIN_TXE];
   assign rxe = main_r[`CSU_MAIN_RXE];
   assign sce = main_r[`CSU_MAIN_SCE];
   assign ext_clk = clk_cfg_r[2:0] == `CSU_CKS_EXT;
   assign len = frame_len(flen_r);

   // APB phases: no wait state, the access completes on its first access edge
   assign setup = psel && !penable;
   assign finish = psel && penable && pready_r;
   assign wr_tx = finish && pwrite && (paddr == `CSU_OFF_TX) && pwr && txe;
   assign wr_stat = finish && pwrite && (paddr == `CSU_OFF_STAT);
   assign rd_rx = finish && !pwrite && (paddr == `CSU_OFF_RX);

   // A pending word enters the shifter when idle or right at a frame's end
   assign load = tx_full_r && txe && pwr && (!loaded_r || core_done);

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign tx_ready_irq = tx_irq_r;
   assign rx_done_irq = rx_irq_r;
   // With transmit disabled the output line rests low
   assign link.serial_out_pin = core_so && txe;

   // Shift engine; polarity applied here so the core always sees type 1 timing
   shift_core i_shift_core (
      .pclk(pclk),
      .presetn(presetn),
      .clear(!pwr),
      .run(pwr && tsf_r && ext_clk),
      .sck_level(link.serial_clock_pin ^ clk_cfg_r[`CSU_CLK_CKP]),
      .si(link.serial_in_pin),
      .lsb_first(main_r[`CSU_MAIN_DIR]),
      .len(len),
      .load(load),
      .load_word(tx_hold_r),
      .so(core_so),
      .frame_done(core_done),
      .rx_word(core_rx)
   );

   // Read data selection
   always_comb
   begin
      stat = 8'h00;
      stat[`CSU_STAT_TSF] = tsf_r;
      stat[`CSU_STAT_OVE] = ovr_r;
      case (paddr)
         `CSU_OFF_MAIN: rd_mux = {24'h000000, main_r};
         `CSU_OFF_CLK: rd_mux = {24'h000000, clk_cfg_r};
         `CSU_OFF_FLEN: rd_mux = {28'h0000000, flen_r};
         `CSU_OFF_STAT: rd_mux = {24'h000000, stat};
         `CSU_OFF_TX: rd_mux = {16'h0000, tx_hold_r};
         `CSU_OFF_RX: rd_mux = {16'h0000, rx_hold_r};
         default: rd_mux = 32'h00000000;
      endcase
   end

   // Bus answer: data and error captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         prdata_r <= 32'h00000000;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
      else
      begin
         pready_r <= psel && !pready_r;
         if (setup)
         begin
            prdata_r <= pwrite ? 32'h00000000 : rd_mux;
            pslverr_r <= !addr_ok(paddr);
         end
      end

   // Configuration registers; software is expected to write 07H and 00H first
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         main_r <= `CSU_MAIN_RST;
         clk_cfg_r <= `CSU_CLK_RST;
         flen_r <= `CSU_FLEN_RST;
      end
      else if (finish && pwrite)
      begin
         if (paddr == `CSU_OFF_MAIN)
            main_r <= pwdata[7:0] & `CSU_MAIN_MASK;
         if (paddr == `CSU_OFF_CLK)
            clk_cfg_r <= pwdata[7:0] & `CSU_CLK_MASK;
         if (paddr == `CSU_OFF_FLEN)
            flen_r <= pwdata[3:0];
      end

   // Transmit holding register; a new write wins over the load that empties it
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         tx_hold_r <= 16'h0000;
         tx_full_r <= 1'b0;
      end
      else if (!pwr)
         tx_full_r <= 1'b0;
      else if (wr_tx)
      begin
         tx_hold_r <= pwdata[15:0];
         tx_full_r <= 1'b1;
      end
      else if (load)
         tx_full_r <= 1'b0;

   // Shifter holds a transmit word from load until its frame ends
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         loaded_r <= 1'b0;
      else if (!pwr)
         loaded_r <= 1'b0;
      else if (load)
         loaded_r <= 1'b1;
      else if (core_done)
         loaded_r <= 1'b0;

   // Transfer-active flag; starting events win over an ending in the same cycle
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         tsf_r <= 1'b0;
      else if (!pwr)
         tsf_r <= 1'b0;
      else if (wr_tx)
         tsf_r <= 1'b1;
      else if (rd_rx && rxe && !txe)
         tsf_r <= 1'b1;
      else if (core_done && txe && !tx_full_r)
         tsf_r <= 1'b0;
      else if (core_done && !txe && !sce)
         tsf_r <= 1'b0;

   // Transmit-ready pulse when the holding register is free again
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         tx_irq_r <= 1'b0;
      else
         tx_irq_r <= load;

   // Receive side; only a mode with reception enabled reports a frame
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         rx_hold_r <= 16'h0000;
         rx_unread_r <= 1'b0;
         rx_irq_r <= 1'b0;
      end
      else
      begin
         rx_irq_r <= core_done && rxe && pwr;
         if (core_done && rxe && pwr)
         begin
            rx_hold_r <= core_rx;
            rx_unread_r <= 1'b1;
         end
         else if (rd_rx || !pwr)
            rx_unread_r <= 1'b0;
      end

   // Overrun: a completed frame finds the last word unread; set beats clear
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         ovr_r <= 1'b0;
      else if (core_done && rxe && pwr && rx_unread_r && !rd_rx)
         ovr_r <= 1'b1;
      else if (wr_stat && !pwdata[`CSU_STAT_OVE])
         ovr_r <= 1'b0;
endmodule : clocked_serial_unit

// ---- rtl/csu_cfg.svh ----
`ifndef CSU_CFG_SVH
`define CSU_CFG_SVH
// Register byte offsets on the APB side
`define CSU_OFF_MAIN 12'h000
`define CSU_OFF_CLK 12'h004
`define CSU_OFF_FLEN 12'h008
`define CSU_OFF_STAT 12'h00C
`define CSU_OFF_TX 12'h010
`define CSU_OFF_RX 12'h014
// Main control field positions and writable bits
`define CSU_MAIN_PWR 7
`define CSU_MAIN_TXE 6
`define CSU_MAIN_RXE 5
`define CSU_MAIN_DIR 4
`define CSU_MAIN_TMS 1
`define CSU_MAIN_SCE 0
`define CSU_MAIN_MASK 8'hF3
// Clock configuration fields
`define CSU_CLK_CKP 4
`define CSU_CLK_DAP 3
`define CSU_CLK_MASK 8'h1F
`define CSU_CKS_EXT 3'h7
// Status fields
`define CSU_STAT_TSF 7
`define CSU_STAT_OVE 0
// Reset values
`define CSU_MAIN_RST 8'h00
`define CSU_CLK_RST 8'h00
`define CSU_FLEN_RST 4'h0
// Frame length: field 0 gives the base length, the largest is the data width
`define CSU_LEN_BASE 5'h08
`define CSU_LEN_MAX 5'h10
`define CSU_FLEN_TOP 4'h8
// Master end: serial clock half period in pclk cycles
`define CSU_HALF_DEF 2
`endif

// ---- rtl/csu_pkg.sv ----
package csu_pkg;
   // Data word as held in the holding and shift registers
   typedef logic [15:0] word_t;
   // Bit position within a frame
   typedef logic [4:0] bit_count_t;
   // Master end sequencing
   typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} master_state_t;
endpackage : csu_pkg

// ---- rtl/csu_link_if.sv ----
`timescale 1ns/1ps
interface csu_link_if;
   logic serial_clock_pin; // Serial clock, made by the master, idle high
   logic serial_in_pin; // Master data into the unit
   logic serial_out_pin; // Unit data out to the master
   modport device (
      input serial_clock_pin,
      input serial_in_pin,
      output serial_out_pin
   );
   modport master (
      output serial_clock_pin,
      output serial_in_pin,
      input serial_out_pin
   );
endinterface : csu_link_if

// ---- rtl/shift_core.sv ----
`timescale 1ns/1ps
module shift_core (
   input wire logic pclk, // System clock
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic clear, // Return counter and data to idle
   input wire logic run, // Serial clock edges are honoured
   input wire logic sck_level, // Serial clock, polarity already applied
   input wire logic si, // Serial input data
   input wire logic lsb_first, // Bit order
   input wire logic [4:0] len, // Frame length in bits
   input wire logic load, // Take load_word as the next frame
   input wire csu_pkg::word_t load_word, // Word to transmit
   output logic so, // Serial output bit
   output logic frame_done, // One-cycle pulse after the last bit
   output csu_pkg::word_t rx_word // Received frame
);
   logic sck_prev_r;
   csu_pkg::bit_count_t cnt_r;
   csu_pkg::word_t tx_w_r;
   csu_pkg::word_t rx_w_r;
   logic so_r;
   logic done_r;
   logic fall;
   logic rise;

   // Position of the current bit inside the word for either order
   function automatic logic [3:0] bit_idx(input logic [4:0] c, input logic [4:0] n,
                                          input logic lsb);
      logic [4:0] pos;
      pos = lsb ? c : 5'(n - 5'h01 - c);
      return pos[3:0];
   endfunction : bit_idx

   // Edges are only seen while running; the previous level is always tracked
   assign fall = run && sck_prev_r && !sck_level;
   assign rise = run && !sck_prev_r && sck_level;
   assign so = so_r;
   assign frame_done = done_r;
   assign rx_word = rx_w_r;

   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         sck_prev_r <= 1'b1;
      else
         sck_prev_r <= sck_level;

   // Transmit word; a load may land at the frame's end
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         tx_w_r <= 16'h0000;
      else if (clear)
         tx_w_r <= 16'h0000;
      else if (load)
         tx_w_r <= load_word;

   // Output changes on the falling edge, so it is stable at the rising one
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         so_r <= 1'b0;
      else if (clear)
         so_r <= 1'b0;
      else if (fall)
         so_r <= tx_w_r[bit_idx(cnt_r, len, lsb_first)];

   // Bit counter and end-of-frame pulse
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         cnt_r <= 5'h00;
         done_r <= 1'b0;
      end
      else if (clear)
      begin
         cnt_r <= 5'h00;
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= rise && (cnt_r == 5'(len - 5'h01));
         if (rise)
            cnt_r <= (cnt_r == 5'(len - 5'h01)) ? 5'h00 : 5'(cnt_r + 5'h01);
      end

   // Input sampled on the rising edge; stale upper bits cleared at frame start
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         rx_w_r <= 16'h0000;
      else if (clear)
         rx_w_r <= 16'h0000;
      else if (rise)
      begin
         if (cnt_r == 5'h00)
            rx_w_r <= 16'h0000;
         rx_w_r[bit_idx(cnt_r, len, lsb_first)] <= si;
      end
endmodule : shift_core

// ---- rtl/serial_master_end.sv ----
`timescale 1ns/1ps
`include "csu_cfg.svh"
module serial_master_end #(
   parameter int BITS = 8,
   parameter int HALF = `CSU_HALF_DEF
) (
   input wire logic pclk, // System clock
   input wire logic presetn, // Asynchronous reset, active low
   input wire logic start, // Begin one frame, taken while not busy
   input wire csu_pkg::word_t tx_word, // Word to send, low BITS used
   output csu_pkg::word_t rx_word, // Word received, low BITS
   output logic busy, // Frame in progress
   output logic done, // One-cycle pulse at frame end
   csu_link_if.master link // Serial link to the unit
);
   csu_pkg::master_state_t st_r;
   logic sck_r;
   logic mo_r;
   logic [7:0] div_r;
   csu_pkg::bit_count_t cnt_r;
   csu_pkg::word_t txw_r;
   csu_pkg::word_t rxw_r;
   logic busy_r;
   logic done_r;

   // The unit needs two cycles to see and act on each edge
   if (BITS < 1 || BITS > 16 || HALF < 2 || HALF > 255)
      $error("serial_master_end: BITS must be 1..16 and HALF 2..255");

   assign link.serial_clock_pin = sck_r;
   assign link.serial_in_pin = mo_r;
   assign rx_word = rxw_r;
   assign busy = busy_r;
   assign done = done_r;

   // Type 1 clocking: drive on the falling edge, sample on the rising edge
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         st_r <= csu_pkg::ST_IDLE;
         sck_r <= 1'b1;
         mo_r <= 1'b0;
         div_r <= 8'h00;
         cnt_r <= 5'h00;
         txw_r <= 16'h0000;
         rxw_r <= 16'h0000;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end
      else
      begin
         done_r <= 1'b0;
         case (st_r)
            csu_pkg::ST_IDLE:
               if (start)
               begin
                  mo_r <= tx_word[BITS-1];
                  txw_r <= tx_word << 1;
                  sck_r <= 1'b0;
                  div_r <= 8'h00;
                  cnt_r <= 5'h00;
                  busy_r <= 1'b1;
                  st_r <= csu_pkg::ST_LOW;
               end
            csu_pkg::ST_LOW:
               if (div_r == 8'(HALF - 1))
               begin
                  div_r <= 8'h00;
                  sck_r <= 1'b1;
                  rxw_r <= {rxw_r[14:0], link.serial_out_pin};
                  st_r <= csu_pkg::ST_HIGH;
               end
               else
                  div_r <= 8'(div_r + 8'h01);
            csu_pkg::ST_HIGH:
               if (div_r != 8'(HALF - 1))
                  div_r <= 8'(div_r + 8'h01);
               else if (cnt_r == 5'(BITS - 1))
               begin
                  div_r <= 8'h00;
                  busy_r <= 1'b0;
                  done_r <= 1'b1;
                  st_r <= csu_pkg::ST_IDLE;
               end
               else
               begin
                  div_r <= 8'h00;
                  cnt_r <= 5'(cnt_r + 5'h01);
                  mo_r <= txw_r[BITS-1];
                  txw_r <= txw_r << 1;
                  sck_r <= 1'b0;
                  st_r <= csu_pkg::ST_LOW;
               end
            default:
               st_r <= csu_pkg::ST_IDLE;
         endcase
      end
endmodule : serial_master_end

// ---- testbench/csu_link_asserts.sv ----
`timescale 1ns/1ps
// Watches the bus handshake, the event pulses and the serial clock between the two ends
module csu_link_asserts (
   input wire logic pclk, // System clock
   input wire logic presetn, // Reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pready, // APB ready from the unit
   input wire logic tx_ready_irq, // Transmit holding free
   input wire logic rx_done_irq, // Received word ready
   input wire logic serial_clock_pin // Serial clock from the master end
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // No wait state: ready is low at the setup edge and high at the first access edge
   a_ready_first_access: assert property ((psel && !penable) |-> !pready ##1 pready)
      else $error("ready not in the first access cycle");
   a_ready_in_access: assert property (pready |-> (psel && penable) ##1 !pready)
      else $error("ready outside a single access cycle");
   a_ready_idle_low: assert property (!psel |-> !pready)
      else $error("ready while not selected");
   // Loads happen while the clock rests high, and never twice in a row
   a_tx_irq_gap: assert property (tx_ready_irq |-> serial_clock_pin ##1 !tx_ready_irq [*8])
      else $error("transmit ready pulse badly placed");
   a_rx_irq_gap: assert property (rx_done_irq |=> !rx_done_irq [*8])
      else $error("reception pulse repeated too soon");
   // Word completes only after the last rising clock edge was sampled
   a_rx_in_high: assert property (rx_done_irq |-> serial_clock_pin && $past(serial_clock_pin))
      else $error("reception pulse outside high clock phase");
   // Half period of at least two cycles keeps the unit's edge detector sound
   a_sck_low_hold: assert property ($fell(serial_clock_pin) |=> !serial_clock_pin)
      else $error("serial clock low phase too short");
   a_sck_high_hold: assert property ($rose(serial_clock_pin) |=> serial_clock_pin)
      else $error("serial clock high phase too short");
endmodule : csu_link_asserts

// ---- testbench/clocked_serial_slave_continuous_tb.sv ----
`timescale 1ns/1ps
`include "csu_cfg.svh"
module clocked_serial_slave_continuous_tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic tx_ready_irq;
   logic rx_done_irq;
   logic start = 1'b0;
   csu_pkg::word_t tx_word = 16'h0000;
   csu_pkg::word_t rx_word;
   logic busy;
   logic done;
   logic [31:0] rd;
   logic last_err;
   int failures = 0;
   int n_checks = 0;
   int cycles = 0;
   int n_tx = 0;
   int n_rx = 0;

   csu_link_if link_if ();

   clocked_serial_unit i_clocked_serial_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tx_ready_irq(tx_ready_irq),
      .rx_done_irq(rx_done_irq), .link(link_if));

   serial_master_end #(.BITS(8), .HALF(2)) i_serial_master_end (.pclk(pclk),
      .presetn(presetn), .start(start), .tx_word(tx_word), .rx_word(rx_word), .busy(busy),
      .done(done), .link(link_if));

   csu_link_asserts i_csu_link_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pready(pready), .tx_ready_irq(tx_ready_irq),
      .rx_done_irq(rx_done_irq), .serial_clock_pin(link_if.serial_clock_pin));

   // 40 MHz system clock
   always #12.5 pclk = ~pclk;

   // Event pulses last one cycle, so count them at every edge
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (tx_ready_irq === 1'b1) n_tx <= n_tx + 1;
      if (rx_done_irq === 1'b1) n_rx <= n_rx + 1;
      if (cycles == 20000)
      begin
         failures = failures + 1;
         finish_test();
      end
   end

   task finish_test;
      if (failures == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : finish_test

   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
         failures = failures + 1;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : check

   // One APB transfer; request held until ready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // Whole-word compare, so unused upper bits must read zero
   task rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(rd, exp);
   endtask : rd_chk

   // One 8-bit frame from the master end; compares what came back from the unit
   task frame(input logic [7:0] m, input logic [7:0] exp_s);
      start <= 1'b1;
      tx_word <= {8'h00, m};
      @(posedge pclk);
      start <= 1'b0;
      @(posedge pclk);
      while (done !== 1'b1) @(posedge pclk);
      repeat (4) @(posedge pclk);
      check({24'h000000, rx_word[7:0]}, {24'h000000, exp_s});
   endtask : frame

   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk(`CSU_OFF_MAIN, 32'h0000_0000);
      rd_chk(`CSU_OFF_CLK, 32'h0000_0000);
      rd_chk(`CSU_OFF_STAT, 32'h0000_0000);
      apb(1'b0, 12'h018, 32'h0000_0000);
      check({31'h0, last_err}, 32'h0000_0001);
      apb(1'b1, `CSU_OFF_CLK, 32'h0000_0007);
      rd_chk(`CSU_OFF_CLK, 32'h0000_0007);
      apb(1'b1, `CSU_OFF_FLEN, 32'h0000_0000);
      rd_chk(`CSU_OFF_FLEN, 32'h0000_0000);
      // Transmit and receive, with a clock before any holding write
      apb(1'b1, `CSU_OFF_MAIN, 32'h0000_00E3);
      rd_chk(`CSU_OFF_MAIN, 32'h0000_00E3);
      frame(8'h3C, 8'h00);
      rd_chk(`CSU_OFF_STAT, 32'h0000_0000);
      apb(1'b1, `CSU_OFF_TX, 32'h0000_00A5);
      rd_chk(`CSU_OFF_STAT, 32'h0000_0080);
      frame(8'h3C, 8'hA5);
      rd_chk(`CSU_OFF_RX, 32'h0000_003C);
      rd_chk(`CSU_OFF_STAT, 32'h0000_0000);
      // Preloaded second word, first received word left unread
      apb(1'b1, `CSU_OFF_TX, 32'h0000_0081);
      apb(1'b1, `CSU_OFF_TX, 32'h0000_0042);
      frame(8'h55, 8'h81);
      frame(8'hAA, 8'h42);
      rd_chk(`CSU_OFF_STAT, 32'h0000_0001);
      rd_chk(`CSU_OFF_RX, 32'h0000_00AA);
      apb(1'b1, `CSU_OFF_STAT, 32'h0000_0000);
      rd_chk(`CSU_OFF_STAT, 32'h0000_0000);
      check(n_tx, 32'd3);
      check(n_rx, 32'd3);
      // Transmit only; power off with a word loaded
      apb(1'b1, `CSU_OFF_MAIN, 32'h0000_00C3);
      apb(1'b1, `CSU_OFF_TX, 32'h0000_0077);
      apb(1'b1, `CSU_OFF_MAIN, 32'h0000_0000);
      rd_chk(`CSU_OFF_STAT, 32'h0000_0000);
      apb(1'b1, `CSU_OFF_MAIN, 32'h0000_00C3);
      apb(1'b1, `CSU_OFF_TX, 32'h0000_005A);
      frame(8'h0F, 8'h5A);
      rd_chk(`CSU_OFF_STAT, 32'h0000_0000);
      check(n_rx, 32'd3);
      check(n_tx, 32'd5);
      // Receive only, started by a dummy read
      apb(1'b1, `CSU_OFF_MAIN, 32'h0000_0000);
      apb(1'b1, `CSU_OFF_MAIN, 32'h0000_00A3);
      apb(1'b0, `CSU_OFF_RX, 32'h0000_0000);
      rd_chk(`CSU_OFF_STAT, 32'h0000_0080);
      frame(8'h99, 8'h00);
      rd_chk(`CSU_OFF_STAT, 32'h0000_0080);
      rd_chk(`CSU_OFF_RX, 32'h0000_0099);
      apb(1'b1, `CSU_OFF_MAIN, 32'h0000_00A2);
      frame(8'h66, 8'h00);
      rd_chk(`CSU_OFF_STAT, 32'h0000_0000);
      rd_chk(`CSU_OFF_RX, 32'h0000_0066);
      check(n_rx, 32'd5);
      // Least significant bit first reverses the byte on the wire
      apb(1'b1, `CSU_OFF_MAIN, 32'h0000_0000);
      apb(1'b1, `CSU_OFF_MAIN, 32'h0000_00F3);
      apb(1'b1, `CSU_OFF_TX, 32'h0000_0001);
      frame(8'h01, 8'h80);
      rd_chk(`CSU_OFF_RX, 32'h0000_0080);
      apb(1'b1, `CSU_OFF_MAIN, 32'h0000_0000);
      finish_test();
   end
endmodule : clocked_serial_slave_continuous_tb
